// ### pbl_brake_logic.v
`timescale 1ns/10ps
`include "pbl_defines.vh"
// Combinational brake decision from the brake control byte
module pbl_brake_logic (
    // Configuration
    input wire [7:0] brake_ctl_in,
    input wire run_in,
    input wire pin_in,
    // Decision
    output wire brake_out,
    output wire pin_trip_out
);
    wire enabled = brake_ctl_in[`PBL_C1_EN];
    wire pin_en = brake_ctl_in[`PBL_C1_PINEN];
    wire stop_sel = brake_ctl_in[`PBL_C1_STOPSEL];
    wire pin_active = (pin_in == brake_ctl_in[`PBL_C1_POL]);
    wire soft_hold = !pin_en && !stop_sel;
    wire stop_hold = !pin_en && stop_sel && !run_in;
    // Both selects set is the illegal pairing and gives no brake
    wire pin_mode = pin_en && !stop_sel;

    assign pin_trip_out = enabled && pin_mode && pin_active;
    assign brake_out = enabled && (soft_hold || stop_hold || pin_trip_out);
endmodule // pbl_brake_logic

// ### pbl_cpu_model.sv
`timescale 1ns/10ps
// Core side of the register port plus the external brake pin
module pbl_cpu_model (
    // Clock
    input wire mclk_in,
    // Register port
    input wire [7:0] rdata_in,
    output reg [7:0] addr_out,
    output reg wr_out,
    output reg [7:0] wdata_out,
    // Brake pin
    output reg pin_out
);
    initial begin
        addr_out = 8'h00;
        wr_out = 1'b0;
        wdata_out = 8'h00;
        pin_out = 1'b1;
    end
    task wr(input [7:0] a, input [7:0] d);
        begin
            @(posedge mclk_in);
            #1 addr_out = a;
            wr_out = 1'b1;
            wdata_out = d;
            @(posedge mclk_in);
            #1 wr_out = 1'b0;
            // Stale data must not look like a valid write
            wdata_out = ~d;
        end
    endtask
    task rd(input [7:0] a, output [7:0] d);
        begin
            @(posedge mclk_in);
            #1 addr_out = a;
            @(negedge mclk_in);
            d = rdata_in;
        end
    endtask
    task pin(input v);
        begin
            @(posedge mclk_in);
            #1 pin_out = v;
        end
    endtask
endmodule // pbl_cpu_model

// ### pbl_defines.vh
`ifndef PBL_DEFINES_VH
`define PBL_DEFINES_VH
// Special function register addresses
`define PBL_ADDR_CON0 8'hDC
`define PBL_ADDR_CON1 8'hDF
`define PBL_ADDR_CON2 8'hD7
`define PBL_ADDR_PERL 8'hD9
`define PBL_ADDR_PERH 8'hD1
`define PBL_ADDR_CMP0L 8'hDA
`define PBL_ADDR_CMP0H 8'hD2
`define PBL_ADDR_CMP1L 8'hDB
`define PBL_ADDR_CMP1H 8'hD3
`define PBL_ADDR_CMP2L 8'hDD
`define PBL_ADDR_CMP2H 8'hD5
`define PBL_ADDR_CMP3L 8'hDE
`define PBL_ADDR_CMP3H 8'hD6
// First control register fields
`define PBL_C0_RUN 7
`define PBL_C0_LOAD 6
`define PBL_C0_UF 5
`define PBL_C0_CLR 4
// Brake control register fields
`define PBL_C1_STOPSEL 7
`define PBL_C1_POL 6
`define PBL_C1_PINEN 5
`define PBL_C1_EN 4
// Third control register fields
`define PBL_C2_FLAG 0
`define PBL_C2_PS_LO 2
`define PBL_C2_PS_HI 3
// Reset values
`define PBL_RST_BYTE 8'h00
`define PBL_RST_WORD 10'h000
// Compare special codes
`define PBL_CMP_ZERO 10'h000
`define PBL_CMP_ONES 10'h3FF
`endif

// ### pbl_prescaler.v
`timescale 1ns/10ps
`include "pbl_defines.vh"
// Tick generator; held in phase with the system clock while stopped
module pbl_prescaler (
    // Clock and reset
    input wire mclk_in,
    input wire rst_b_in,
    // Control
    input wire run_in,
    input wire [1:0] sel_in,
    // Tick
    output wire tick_out
);
    reg [3:0] div_reg;
    reg [3:0] div_next;
    reg [3:0] mask;

    always @* begin
        case (sel_in)
            2'b00: mask = 4'h0;
            2'b01: mask = 4'h1;
            2'b10: mask = 4'h3;
            default: mask = 4'hF;
        endcase
    end

    // Restarting from zero while stopped keeps phase fixed at run start
    always @* begin
        if (!run_in) begin
            div_next = 4'h0;
        end else if ((div_reg & mask) == mask) begin
            div_next = 4'h0;
        end else begin
            div_next = div_reg + 4'h1;
        end
    end

    always @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            div_reg <= 4'h0;
        end else begin
            div_reg <= div_next;
        end
    end

    assign tick_out = run_in && ((div_reg & mask) == mask);
endmodule // pbl_prescaler

// ### pbl_pwm_ctrl.v
`timescale 1ns/10ps
`include "pbl_defines.vh"
module pbl_pwm_ctrl #(
    parameter CNT_W = 10
) (
    // Clock and reset
    input wire mclk_in,
    input wire rst_b_in,
    // Special function register port
    input wire [7:0] sfr_addr_in,
    input wire sfr_wr_in,
    input wire [7:0] sfr_wdata_in,
    output reg [7:0] sfr_rdata_out,
    // External brake pin
    input wire external_brake_input_in,
    // Channel outputs
    output wire [3:0] pwm_out,
    output wire underflow_flag_out
);
    reg counter_run_enable_reg;
    reg load_req_reg;
    reg underflow_flag_reg;
    reg [3:0] channel_invert_reg;
    reg [7:0] brake_ctl_reg;
    reg pin_brake_flag_reg;
    reg [1:0] prescale_select_reg;
    reg [CNT_W-1:0] period_hold_reg;
    reg [CNT_W-1:0] period_work_reg;
    reg [CNT_W-1:0] count_reg;
    reg clr_req_reg;
    wire tick;
    wire brake;
    wire pin_trip;
    wire underflow;
    wire [3:0] channel_brake_levels = brake_ctl_reg[3:0];
    wire wr_con0 = sfr_wr_in && (sfr_addr_in == `PBL_ADDR_CON0);
    wire wr_con2 = sfr_wr_in && (sfr_addr_in == `PBL_ADDR_CON2);

    pbl_prescaler u_prescaler (
        .mclk_in(mclk_in),
        .rst_b_in(rst_b_in),
        .run_in(counter_run_enable_reg),
        .sel_in(prescale_select_reg),
        .tick_out(tick)
    );

    pbl_brake_logic u_brake (
        .brake_ctl_in(brake_ctl_reg),
        .run_in(counter_run_enable_reg),
        .pin_in(external_brake_input_in),
        .brake_out(brake),
        .pin_trip_out(pin_trip)
    );

    // Underflow needs a running counter, so a stopped unit never transfers
    assign underflow = tick && (count_reg == {CNT_W{1'b0}});

    // First control register: run, load, underflow flag, invert bits
    always @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            counter_run_enable_reg <= 1'b0;
            load_req_reg <= 1'b0;
            underflow_flag_reg <= 1'b0;
            clr_req_reg <= 1'b0;
            channel_invert_reg <= 4'h0;
        end else begin
            clr_req_reg <= wr_con0 && sfr_wdata_in[`PBL_C0_CLR];
            if (wr_con0) begin
                channel_invert_reg <= sfr_wdata_in[3:0];
                counter_run_enable_reg <= sfr_wdata_in[`PBL_C0_RUN];
                // Rewriting load as 0 drops a pending transfer
                load_req_reg <= sfr_wdata_in[`PBL_C0_LOAD];
            end else if (underflow && load_req_reg) begin
                load_req_reg <= 1'b0;
            end
            // Pin brake stops the counter regardless of software writes
            if (pin_trip) begin
                counter_run_enable_reg <= 1'b0;
            end
            // Hardware set wins over a software clear in the same cycle
            if (underflow) begin
                underflow_flag_reg <= 1'b1;
            end else if (wr_con0) begin
                underflow_flag_reg <= sfr_wdata_in[`PBL_C0_UF];
            end
        end
    end

    // Brake control and third control register
    always @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            brake_ctl_reg <= `PBL_RST_BYTE;
            pin_brake_flag_reg <= 1'b0;
            prescale_select_reg <= 2'b00;
        end else begin
            if (sfr_wr_in && (sfr_addr_in == `PBL_ADDR_CON1)) begin
                brake_ctl_reg <= sfr_wdata_in;
            end
            if (wr_con2) begin
                prescale_select_reg <= sfr_wdata_in[`PBL_C2_PS_HI:`PBL_C2_PS_LO];
            end
            // Sticky until software writes it low; the set wins
            if (pin_trip) begin
                pin_brake_flag_reg <= 1'b1;
            end else if (wr_con2) begin
                pin_brake_flag_reg <= sfr_wdata_in[`PBL_C2_FLAG];
            end
        end
    end

    // Holding registers and working registers
    always @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            period_hold_reg <= `PBL_RST_WORD;
            period_work_reg <= `PBL_RST_WORD;
        end else begin
            if (sfr_wr_in && (sfr_addr_in == `PBL_ADDR_PERL)) begin
                period_hold_reg[7:0] <= sfr_wdata_in;
            end
            if (sfr_wr_in && (sfr_addr_in == `PBL_ADDR_PERH)) begin
                period_hold_reg[CNT_W-1:8] <= sfr_wdata_in[CNT_W-9:0];
            end
            if (underflow && load_req_reg) begin
                period_work_reg <= period_hold_reg;
            end
        end
    end

    genvar ch;
    generate
        for (ch = 0; ch < 4; ch = ch + 1) begin : g_chan
            wire [7:0] addr_lo = (ch == 0) ? `PBL_ADDR_CMP0L : (ch == 1) ? `PBL_ADDR_CMP1L :
                                 (ch == 2) ? `PBL_ADDR_CMP2L : `PBL_ADDR_CMP3L;
            wire [7:0] addr_hi = (ch == 0) ? `PBL_ADDR_CMP0H : (ch == 1) ? `PBL_ADDR_CMP1H :
                                 (ch == 2) ? `PBL_ADDR_CMP2H : `PBL_ADDR_CMP3H;
            // Per-channel state kept local so each register has one process
            reg [CNT_W-1:0] cmp_hold_reg;
            reg [CNT_W-1:0] cmp_work_reg;
            reg wave_reg;
            reg pwm_reg;
            always @(posedge mclk_in or negedge rst_b_in) begin
                if (!rst_b_in) begin
                    cmp_hold_reg <= `PBL_RST_WORD;
                    cmp_work_reg <= `PBL_RST_WORD;
                    wave_reg <= 1'b0;
                    pwm_reg <= 1'b0;
                end else begin
                    if (sfr_wr_in && (sfr_addr_in == addr_lo)) begin
                        cmp_hold_reg[7:0] <= sfr_wdata_in;
                    end
                    if (sfr_wr_in && (sfr_addr_in == addr_hi)) begin
                        cmp_hold_reg[CNT_W-1:8] <= sfr_wdata_in[CNT_W-9:0];
                    end
                    if (underflow && load_req_reg) begin
                        cmp_work_reg <= cmp_hold_reg;
                    end
                    // Waveform only advances while running, else it holds
                    if (tick) begin
                        if (cmp_work_reg == `PBL_CMP_ZERO) begin
                            wave_reg <= 1'b1;
                        end else if (cmp_work_reg == `PBL_CMP_ONES) begin
                            wave_reg <= 1'b0;
                        end else begin
                            wave_reg <= (count_reg < cmp_work_reg);
                        end
                    end
                    // Brake overrides; on release the held wave reappears
                    if (brake) begin
                        pwm_reg <= channel_brake_levels[ch];
                    end else begin
                        pwm_reg <= wave_reg ^ channel_invert_reg[ch];
                    end
                end
            end
            assign pwm_out[ch] = pwm_reg;
        end
    endgenerate

    // Down counter, reloaded at underflow from the holding period if a load is pending, else from the working period
    always @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            count_reg <= `PBL_RST_WORD;
        end else if (clr_req_reg) begin
            count_reg <= `PBL_RST_WORD;
        end else if (underflow) begin
            count_reg <= load_req_reg ? period_hold_reg : period_work_reg;
        end else if (tick) begin
            count_reg <= count_reg - {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

    // Read mux; reserved bits read zero
    always @* begin
        if (sfr_addr_in == `PBL_ADDR_CON0) begin
            sfr_rdata_out = {counter_run_enable_reg, load_req_reg, underflow_flag_reg,
                             1'b0, channel_invert_reg};
        end else if (sfr_addr_in == `PBL_ADDR_CON1) begin
            sfr_rdata_out = brake_ctl_reg;
        end else if (sfr_addr_in == `PBL_ADDR_CON2) begin
            sfr_rdata_out = {4'h0, prescale_select_reg, 1'b0, pin_brake_flag_reg};
        end else if (sfr_addr_in == `PBL_ADDR_PERL) begin
            sfr_rdata_out = period_hold_reg[7:0];
        end else if (sfr_addr_in == `PBL_ADDR_PERH) begin
            sfr_rdata_out = {6'h00, period_hold_reg[CNT_W-1:8]};
        end else begin
            sfr_rdata_out = 8'h00;
        end
    end

    assign underflow_flag_out = underflow_flag_reg;
endmodule // pbl_pwm_ctrl

// ### pbl_pwm_ctrl_checker.sv
`timescale 1ns/10ps
`include "pbl_defines.vh"
module pbl_pwm_ctrl_checker #(
    parameter CNT_W = 10
) (
    // Clock and reset
    input wire mclk_in,
    input wire rst_b_in,
    // Register port
    input wire [7:0] sfr_addr_in,
    input wire sfr_wr_in,
    input wire [7:0] sfr_wdata_in,
    input wire [7:0] sfr_rdata_out,
    // Pins
    input wire external_brake_input_in,
    input wire [3:0] pwm_out,
    input wire underflow_flag_out
);
    reg [7:0] brk_reg;
    wire [7:0] a = sfr_addr_in;
    wire [7:0] rd = sfr_rdata_out;
    wire sw_brk = brk_reg[4] & ~brk_reg[5] & ~brk_reg[7];
    wire stop_brk = brk_reg[4] & ~brk_reg[5] & brk_reg[7];
    wire pin_brk = brk_reg[4] & brk_reg[5] & ~brk_reg[7] & (external_brake_input_in == brk_reg[6]);
    // Brake byte shadow, rebuilt from the write port alone
    always @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            brk_reg <= 8'h00;
        end else if (sfr_wr_in && a == `PBL_ADDR_CON1) begin
            brk_reg <= sfr_wdata_in;
        end
    end
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_b_in);
    AST_CON2_RSVD: assert property (
        a == `PBL_ADDR_CON2 |-> (rd & 8'hF2) == 8'h00) else $error("reserved bits set");
    AST_CON1_RB: assert property (
        sfr_wr_in && a == `PBL_ADDR_CON1 ##1 a == `PBL_ADDR_CON1 |-> rd == $past(sfr_wdata_in))
        else $error("brake control readback wrong");
    AST_CON0_RB: assert property (
        sfr_wr_in && a == `PBL_ADDR_CON0 ##1 a == `PBL_ADDR_CON0
        |-> rd[3:0] == $past(sfr_wdata_in[3:0])) else $error("invert bits readback wrong");
    AST_CON2_RB: assert property (
        sfr_wr_in && a == `PBL_ADDR_CON2 ##1 a == `PBL_ADDR_CON2
        |-> rd[3:2] == $past(sfr_wdata_in[3:2])) else $error("prescale readback wrong");
    AST_CMP_WO: assert property (
        a == `PBL_ADDR_CMP0L |-> rd == 8'h00) else $error("compare holding reads nonzero");
    AST_SW_BRAKE: assert property (
        sw_brk |=> pwm_out == $past(brk_reg[3:0])) else $error("software brake levels wrong");
    AST_STOP_BRAKE: assert property (
        stop_brk && a == `PBL_ADDR_CON0 && !rd[7] |=> pwm_out == $past(brk_reg[3:0]))
        else $error("stop brake levels wrong");
    AST_PIN_BRAKE: assert property (
        pin_brk |-> ##[1:3] pwm_out == brk_reg[3:0]) else $error("pin brake levels wrong");
    AST_FLAG_STICKY: assert property (
        a == `PBL_ADDR_CON2 && rd[0] && !sfr_wr_in ##1 a == `PBL_ADDR_CON2 |-> rd[0])
        else $error("pin brake flag dropped");
    AST_LOAD_HELD: assert property (
        a == `PBL_ADDR_CON0 && rd[6] && !rd[7] && !sfr_wr_in ##1 a == `PBL_ADDR_CON0 |-> rd[6])
        else $error("load request dropped while stopped");
    cover property (sw_brk ##1 pwm_out == brk_reg[3:0]);
    cover property (pin_brk);
    cover property (stop_brk && a == `PBL_ADDR_CON0 && !rd[7]);
endmodule // pbl_pwm_ctrl_checker

// ### tb_pbl_pwm_ctrl.sv
`timescale 1ns/10ps
`include "pbl_defines.vh"
module tb_pbl_pwm_ctrl;
    reg mclk = 1'b0;
    reg rst_b = 1'b0;
    wire [7:0] addr, wdata, rdata;
    wire wr, pin, uf;
    wire [3:0] pwm;
    reg [7:0] d;
    integer num_errors = 0;
    integer num_checks = 0;
    integer i, n;
    always #4 mclk = ~mclk;
    pbl_pwm_ctrl pbl_pwm_ctrl_i (.mclk_in(mclk), .rst_b_in(rst_b), .sfr_addr_in(addr),
        .sfr_wr_in(wr), .sfr_wdata_in(wdata), .sfr_rdata_out(rdata),
        .external_brake_input_in(pin), .pwm_out(pwm), .underflow_flag_out(uf));
    pbl_cpu_model pbl_cpu_model_i (.mclk_in(mclk), .rdata_in(rdata), .addr_out(addr),
        .wr_out(wr), .wdata_out(wdata), .pin_out(pin));
    task conclude;
        begin
            $display("checks %0d errors %0d", num_checks, num_errors);
            if (num_errors == 0 && num_checks > 0) $display("Finished cleanly");
            else $display("Finished with errors");
            $finish;
        end
    endtask
    task chk(input string what, input [7:0] exp, input [7:0] got);
        begin
            num_checks = num_checks + 1;
            if (got !== exp) begin
                num_errors = num_errors + 1;
                $display("[ERR] %0s expected %h seen %h", what, exp, got);
            end
        end
    endtask
    task w(input [7:0] a, input [7:0] v);
        pbl_cpu_model_i.wr(a, v);
    endtask
    task r(input [7:0] a);
        pbl_cpu_model_i.rd(a, d);
    endtask
    task fail;
        begin
            num_errors = num_errors + 1;
            conclude;
        end
    endtask
    task wait_load;
        begin
            n = 0;
            d = 8'h40;
            while (d[6] === 1'b1 && n < 100) begin
                r(`PBL_ADDR_CON0);
                n = n + 1;
            end
            if (n >= 100) fail;
        end
    endtask
    task pwm_is(input [3:0] v);
        begin
            repeat (3) @(negedge mclk);
            chk("pwm", {4'h0, v}, {4'h0, pwm});
        end
    endtask
    // Cycles from the current point to the next rising edge of channel 0
    task rise;
        begin
            n = 0;
            while (pwm[0] !== 1'b0 && n < 200) begin @(negedge mclk); n = n + 1; end
            while (pwm[0] !== 1'b1 && n < 200) begin @(negedge mclk); n = n + 1; end
            if (n >= 200) fail;
        end
    endtask
    task t_regs;
        begin
            r(`PBL_ADDR_CON1); chk("con1", 8'h00, d);
            r(`PBL_ADDR_CON2); chk("con2", 8'h00, d);
            w(8'h00, 8'hFF); r(8'h00); chk("unmapped", 8'h00, d);
            w(`PBL_ADDR_CMP0L, 8'h55); r(`PBL_ADDR_CMP0L); chk("cmp0l", 8'h00, d);
            w(`PBL_ADDR_CON2, 8'hFF); r(`PBL_ADDR_CON2); chk("con2", 8'h0D, d);
            w(`PBL_ADDR_CON2, 8'h00); r(`PBL_ADDR_CON2); chk("con2", 8'h00, d);
        end
    endtask
    task t_sw;
        begin
            w(`PBL_ADDR_CON1, 8'h1A); pwm_is(4'hA);
            w(`PBL_ADDR_CON1, 8'h15); pwm_is(4'h5);
            w(`PBL_ADDR_CON1, 8'h00);
        end
    endtask
    task t_load;
        begin
            w(`PBL_ADDR_PERL, 8'h03);
            w(`PBL_ADDR_PERH, 8'h00);
            // Channels 0 and 2 always high, 1 and 3 always low
            w(`PBL_ADDR_CMP0L, 8'h00);
            w(`PBL_ADDR_CMP0H, 8'h00);
            w(`PBL_ADDR_CMP1L, 8'hFF);
            w(`PBL_ADDR_CMP1H, 8'h03);
            w(`PBL_ADDR_CMP2L, 8'h00);
            w(`PBL_ADDR_CMP2H, 8'h00);
            w(`PBL_ADDR_CMP3L, 8'hFF);
            w(`PBL_ADDR_CMP3H, 8'h03);
            w(`PBL_ADDR_CON0, 8'h40); r(`PBL_ADDR_CON0);
            repeat (20) @(posedge mclk);
            r(`PBL_ADDR_CON0); chk("con0", 8'h40, d);
            w(`PBL_ADDR_CON0, 8'hC0);
            wait_load;
            chk("uflag", 8'h01, {7'h0, uf});
            pwm_is(4'h5);
            w(`PBL_ADDR_CON0, 8'h00);
            repeat (10) @(posedge mclk);
            pwm_is(4'h5);
        end
    endtask
    task t_stop;
        begin
            w(`PBL_ADDR_CON1, 8'h96); r(`PBL_ADDR_CON0); pwm_is(4'h6);
            // Pin active and run clear, yet both selects set must give no brake
            w(`PBL_ADDR_CON1, 8'hF6);
            pwm_is(4'h5);
            r(`PBL_ADDR_CON2);
            chk("flag", 8'h00, {7'h0, d[0]});
            w(`PBL_ADDR_CON1, 8'h96);
            pwm_is(4'h6);
            w(`PBL_ADDR_CON1, 8'h86); r(`PBL_ADDR_CON0); pwm_is(4'h5);
        end
    endtask
    // Slow prescale leaves time to cancel the load before any underflow
    task t_cancel;
        begin
            w(`PBL_ADDR_CON2, 8'h0C);
            w(`PBL_ADDR_CMP0L, 8'h02);
            w(`PBL_ADDR_CON0, 8'hC0);
            w(`PBL_ADDR_CON0, 8'h80);
            repeat (12) begin
                repeat (7) @(negedge mclk);
                pwm_is(4'h5);
            end
            w(`PBL_ADDR_CON2, 8'h00);
        end
    endtask
    task t_prescale;
        begin
            w(`PBL_ADDR_CON1, 8'h00);
            w(`PBL_ADDR_CMP0L, 8'h02);
            w(`PBL_ADDR_CON0, 8'hC0);
            wait_load;
            for (i = 0; i < 4; i = i + 1) begin
                w(`PBL_ADDR_CON2, {4'h0, i[1:0], 2'b00});
                rise;
                rise;
                chk("period", (i == 3) ? 8'h40 : 8'h04 << i, n[7:0]);
            end
        end
    endtask
    task t_pin;
        begin
            w(`PBL_ADDR_CON0, 8'h00);
            w(`PBL_ADDR_CON2, 8'h00);
            w(`PBL_ADDR_CON1, 8'h39);
            w(`PBL_ADDR_CON0, 8'hC0);
            wait_load;
            pbl_cpu_model_i.pin(1'b0);
            pwm_is(4'h9);
            pbl_cpu_model_i.pin(1'b1);
            r(`PBL_ADDR_CON2); chk("flag", 8'h01, {7'h0, d[0]});
            r(`PBL_ADDR_CON0); chk("run", 8'h00, {7'h0, d[7]});
            w(`PBL_ADDR_CON2, 8'h00); r(`PBL_ADDR_CON2); chk("flag", 8'h00, d);
            w(`PBL_ADDR_CON1, 8'h00);
            pbl_cpu_model_i.pin(1'b0);
            w(`PBL_ADDR_CON1, 8'h79);
            w(`PBL_ADDR_CON0, 8'hC0);
            repeat (5) @(posedge mclk);
            r(`PBL_ADDR_CON2); chk("flag", 8'h00, {7'h0, d[0]});
            pbl_cpu_model_i.pin(1'b1);
            repeat (3) @(posedge mclk);
            r(`PBL_ADDR_CON2); chk("flag", 8'h01, {7'h0, d[0]});
        end
    endtask
    initial begin
        repeat (4) @(posedge mclk);
        #1 rst_b = 1'b1;
        t_regs;
        t_sw;
        t_load;
        t_stop;
        t_cancel;
        t_prescale;
        t_pin;
        conclude;
    end
endmodule // tb_pbl_pwm_ctrl
bind pbl_pwm_ctrl pbl_pwm_ctrl_checker #(.CNT_W(CNT_W)) pbl_pwm_ctrl_checker_i (
    .mclk_in(mclk_in), .rst_b_in(rst_b_in), .sfr_addr_in(sfr_addr_in),
    .sfr_wr_in(sfr_wr_in), .sfr_wdata_in(sfr_wdata_in), .sfr_rdata_out(sfr_rdata_out),
    .external_brake_input_in(external_brake_input_in), .pwm_out(pwm_out),
    .underflow_flag_out(underflow_flag_out));
